// >>> design/srwg_pkg.sv
package srwg_pkg;

  // bus geometry
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;

  // clock and pin timing
  localparam int CLK_NS       = 50;
  localparam int STROBE_NS    = 100;  // least width of a write or read strobe
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_LAT     = 2;    // synchroniser depth on the data lines
  localparam int HWRST_NS     = 500;  // least low time of the device reset pin
  localparam int HWRST_CYC    = (HWRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 8;

  // secured region layout
  localparam logic [ADDR_W-1:0] SEC_LAST    = 23'h00_007F;
  localparam logic [ADDR_W-1:0] CUST_FIRST  = 23'h00_0040;
  localparam logic [ADDR_W-1:0] FLAG_ADDR   = 23'h00_0000;
  localparam logic [ADDR_W-1:0] LOCK_ADDR   = 23'h00_0002;
  localparam int                FACTORY_BIT = 7;
  localparam int                CUST_BIT    = 6;

  // command sequence words
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h00_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h00_02AA;
  localparam logic [ADDR_W-1:0] QUERY_A   = 23'h00_0055;
  localparam logic [ADDR_W-1:0] ZERO_A    = 23'h00_0000;
  localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
  localparam logic [DATA_W-1:0] ENTER_D   = 16'h0088;
  localparam logic [DATA_W-1:0] EXIT_D    = 16'h0090;
  localparam logic [DATA_W-1:0] PROG_D    = 16'h00A0;
  localparam logic [DATA_W-1:0] PROTECT_D = 16'h0060;
  localparam logic [DATA_W-1:0] QUERY_D   = 16'h0098;
  localparam logic [DATA_W-1:0] RESET_D   = 16'h00F0;
  localparam logic [DATA_W-1:0] ZERO_D    = 16'h0000;

  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_ENTER_SEC, OP_EXIT_SEC, OP_READ_SEC, OP_PROG_SEC,
    OP_LOCK_CUST, OP_READ_FLAGS, OP_QUERY, OP_RESET_CMD, OP_HW_RESET
  } srwg_op_t;

  typedef struct packed {
    srwg_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srwg_cmd_t;

  typedef struct packed {
    logic              rd;
    logic              last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srwg_step_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
  } srwg_pins_t;

  // one bus cycle of a command sequence, picked by operation and step number
  function automatic srwg_step_t srwg_seq(srwg_op_t op, logic [2:0] idx,
                                          logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    srwg_step_t s;
    s = '{rd: 1'b0, last: 1'b0, addr: UNLOCK_A1, data: UNLOCK_D1};
    if (idx == 3'd1)
    begin
      s.addr = UNLOCK_A2;
      s.data = UNLOCK_D2;
    end
    case (op)
      OP_ENTER_SEC:
      begin
        s.last = (idx == 3'd2);
        if (idx == 3'd2) s.data = ENTER_D;
      end
      OP_EXIT_SEC:
      begin
        s.last = (idx == 3'd3);
        if (idx == 3'd2) s.data = EXIT_D;
        if (idx == 3'd3) s = '{rd: 1'b0, last: 1'b1, addr: ZERO_A, data: ZERO_D};
      end
      OP_PROG_SEC:
      begin
        s.last = (idx == 3'd3);
        if (idx == 3'd2) s.data = PROG_D;
        if (idx == 3'd3) s = '{rd: 1'b0, last: 1'b1, addr: a, data: d};
      end
      OP_LOCK_CUST:
        s = '{rd: (idx == 3'd2), last: (idx == 3'd2), addr: LOCK_ADDR, data: PROTECT_D};
      OP_READ_ARRAY, OP_READ_SEC:
        s = '{rd: 1'b1, last: 1'b1, addr: a, data: ZERO_D};
      OP_READ_FLAGS:
        s = '{rd: 1'b1, last: 1'b1, addr: FLAG_ADDR, data: ZERO_D};
      OP_QUERY:
        s = '{rd: 1'b0, last: 1'b1, addr: QUERY_A, data: QUERY_D};
      default:
        s = '{rd: 1'b0, last: 1'b1, addr: ZERO_A, data: RESET_D};
    endcase
    return s;
  endfunction

endpackage

// >>> design/srwg_bus_cycle.sv
`timescale 1ns/1ns
module srwg_bus_cycle
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  srwg_pkg::srwg_step_t             step,
  input  wire logic [srwg_pkg::DATA_W-1:0] dq_in,
  output logic                             busy,
  output logic                             done,
  output logic [srwg_pkg::DATA_W-1:0]      rdata,
  output srwg_pkg::srwg_pins_t             pins
);

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} srwg_ph_t;

  srwg_ph_t                      ph_reg, ph_next;
  logic [srwg_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
  logic                          rd_reg, rd_next;
  logic [srwg_pkg::DATA_W-1:0]   rdata_reg, rdata_next;
  srwg_pkg::srwg_pins_t          pins_reg, pins_next;
  logic [srwg_pkg::DATA_W-1:0]   dq_s1_reg, dq_s2_reg;
  logic                          done_reg, done_next;

  // two-stage synchroniser on the data lines
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end
    else
    begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // phase sequencing: setup, strobe low, strobe high with hold
  always_comb
  begin
    ph_next    = ph_reg;
    cnt_next   = cnt_reg;
    rd_next    = rd_reg;
    rdata_next = rdata_reg;
    pins_next  = pins_reg;
    done_next  = 1'b0;
    case (ph_reg)
      PH_IDLE:
        if (start)
        begin
          ph_next          = PH_SETUP;
          rd_next          = step.rd;
          pins_next.addr   = step.addr;
          pins_next.dq_out = step.data;
          pins_next.dq_oe  = !step.rd;
          pins_next.cs_n   = 1'b0;
        end
      PH_SETUP:
      begin
        ph_next = PH_STROBE;
        // write strobe only with chip select low and output enable high
        pins_next.we_n = rd_reg;
        pins_next.oe_n = !rd_reg;
        cnt_next = rd_reg ? 8'(srwg_pkg::STROBE_CYC + srwg_pkg::SYNC_LAT) : 8'(srwg_pkg::STROBE_CYC);
      end
      PH_STROBE:
        if (cnt_reg <= 8'd1)
        begin
          ph_next        = PH_HOLD;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          if (rd_reg) rdata_next = dq_s2_reg;
        end
        else
          cnt_next = cnt_reg - 8'd1;
      PH_HOLD:
      begin
        ph_next         = PH_IDLE;
        pins_next.cs_n  = 1'b1;
        pins_next.dq_oe = 1'b0;
        done_next       = 1'b1;
      end
      default:
        ph_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ph_reg    <= PH_IDLE;
      cnt_reg   <= 8'h00;
      rd_reg    <= 1'b0;
      rdata_reg <= 16'h0000;
      pins_reg  <= '{addr: 23'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      done_reg  <= 1'b0;
    end
    else
    begin
      ph_reg    <= ph_next;
      cnt_reg   <= cnt_next;
      rd_reg    <= rd_next;
      rdata_reg <= rdata_next;
      pins_reg  <= pins_next;
      done_reg  <= done_next;
    end
  end

  assign busy  = (ph_reg != PH_IDLE);
  assign done  = done_reg;
  assign rdata = rdata_reg;
  assign pins  = pins_reg;

  // a write strobe never overlaps output enable and always sits inside chip select
  property p_write_gate;
    @(posedge clk) disable iff (rst)
      !pins_reg.we_n |-> (!pins_reg.cs_n && pins_reg.oe_n && pins_reg.dq_oe);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write strobe outside legal gating");

  // chip select was already low before the write strobe fell
  property p_cs_before_we;
    @(posedge clk) disable iff (rst)
      $fell(pins_reg.we_n) |-> $past(!pins_reg.cs_n);
  endproperty
  a_cs_before_we: assert property (p_cs_before_we) else $error("write strobe fell without chip select");

endmodule

// >>> design/srwg_host.sv
`timescale 1ns/1ns
// Notes on behaviour
// - after the enter sequence, secured words are read at the boot addresses.
// - host locks the customer half by entering secured mode, then protecting.
// - host exits secured mode before touching the rest of the array.
// - writes need select and write strobe low with output enable high.
module srwg_host
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cmd_valid,
  input  srwg_pkg::srwg_cmd_t              cmd,
  output logic                             cmd_ready,
  output logic                             rsp_valid,
  output logic                             rsp_err,
  output logic [srwg_pkg::DATA_W-1:0]      rsp_data,
  output logic                             secured_mode,
  output logic                             factory_lock_flag,
  output logic                             customer_lock_flag,
  input  wire logic                        supply_ok,
  input  wire logic [srwg_pkg::DATA_W-1:0] dq_in,
  output srwg_pkg::srwg_pins_t             pins,
  output logic                             flash_reset_n
);

  typedef enum logic [1:0] {ST_HWRST, ST_IDLE, ST_ISSUE, ST_WAIT} srwg_st_t;

  srwg_st_t                     st_reg, st_next;
  srwg_pkg::srwg_cmd_t          cur_reg, cur_next;
  logic [2:0]                   idx_reg, idx_next;
  logic [srwg_pkg::CNT_W-1:0]   rcnt_reg, rcnt_next;
  logic                         sec_reg, sec_next;
  logic                         fac_reg, fac_next;
  logic                         cust_reg, cust_next;
  logic                         rv_reg, rv_next;
  logic                         re_reg, re_next;
  logic [srwg_pkg::DATA_W-1:0]  rd_reg, rd_next;
  logic                         sup_s1_reg, sup_s2_reg;
  logic                         eng_busy, eng_done, eng_start, refuse;
  logic [srwg_pkg::DATA_W-1:0]  eng_rdata;
  srwg_pkg::srwg_step_t         step;

  // supply-good level from the monitor passes two flip-flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
    end
    else
    begin
      sup_s1_reg <= supply_ok;
      sup_s2_reg <= sup_s1_reg;
    end
  end

  // current bus cycle of the running command sequence
  assign step      = srwg_pkg::srwg_seq(cur_reg.op, idx_reg, cur_reg.addr, cur_reg.data);
  assign eng_start = (st_reg == ST_ISSUE);
  assign cmd_ready = (st_reg == ST_IDLE);

  // host-side screening of a command before it reaches the pins
  always_comb
  begin
    refuse = 1'b0;
    case (cmd.op)
      srwg_pkg::OP_READ_ARRAY:
        refuse = sec_reg;
      srwg_pkg::OP_READ_SEC, srwg_pkg::OP_READ_FLAGS:
        refuse = !sec_reg || (cmd.addr > srwg_pkg::SEC_LAST);
      srwg_pkg::OP_PROG_SEC:
        refuse = !sec_reg || (cmd.addr > srwg_pkg::SEC_LAST)
                 || (cmd.addr < srwg_pkg::CUST_FIRST) || cust_reg;
      srwg_pkg::OP_LOCK_CUST:
        refuse = !sec_reg || cust_reg;
      srwg_pkg::OP_HW_RESET:
        refuse = 1'b0;
      default:
        refuse = 1'b0;
    endcase
    // no writes while the supply is below the lockout level
    if (!sup_s2_reg && cmd.op != srwg_pkg::OP_HW_RESET && cmd.op != srwg_pkg::OP_READ_ARRAY
        && cmd.op != srwg_pkg::OP_READ_SEC && cmd.op != srwg_pkg::OP_READ_FLAGS)
      refuse = 1'b1;
  end

  // command sequencer and mode tracking
  always_comb
  begin
    st_next   = st_reg;
    cur_next  = cur_reg;
    idx_next  = idx_reg;
    rcnt_next = rcnt_reg;
    sec_next  = sec_reg;
    fac_next  = fac_reg;
    cust_next = cust_reg;
    rv_next   = 1'b0;
    re_next   = 1'b0;
    rd_next   = rd_reg;
    // the device drops to read mode on a supply dip
    if (!sup_s2_reg) sec_next = 1'b0;
    case (st_reg)
      ST_HWRST:
      begin
        sec_next = 1'b0;
        if (rcnt_reg <= 8'd1)
        begin
          st_next = ST_IDLE;
          if (cur_reg.op == srwg_pkg::OP_HW_RESET) rv_next = 1'b1;
        end
        else
          rcnt_next = rcnt_reg - 8'd1;
      end
      ST_IDLE:
        if (cmd_valid)
        begin
          cur_next = cmd;
          idx_next = 3'd0;
          if (refuse)
          begin
            rv_next = 1'b1;
            re_next = 1'b1;
          end
          else if (cmd.op == srwg_pkg::OP_HW_RESET)
          begin
            st_next   = ST_HWRST;
            rcnt_next = 8'(srwg_pkg::HWRST_CYC);
          end
          else
            st_next = ST_ISSUE;
        end
      ST_ISSUE:
        st_next = ST_WAIT;
      ST_WAIT:
        if (eng_done)
        begin
          if (!step.last)
          begin
            idx_next = idx_reg + 3'd1;
            st_next  = ST_ISSUE;
          end
          else
          begin
            st_next = ST_IDLE;
            rv_next = 1'b1;
            rd_next = eng_rdata;
            case (cur_reg.op)
              srwg_pkg::OP_ENTER_SEC: sec_next = 1'b1;
              srwg_pkg::OP_EXIT_SEC:  sec_next = 1'b0;
              srwg_pkg::OP_LOCK_CUST: cust_next = 1'b1;
              srwg_pkg::OP_READ_FLAGS:
              begin
                fac_next  = eng_rdata[srwg_pkg::FACTORY_BIT];
                cust_next = cust_reg | eng_rdata[srwg_pkg::CUST_BIT];
              end
              default: sec_next = sec_next;
            endcase
          end
        end
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg   <= ST_HWRST;
      cur_reg  <= '{op: srwg_pkg::OP_READ_ARRAY, addr: 23'h00_0000, data: 16'h0000};
      idx_reg  <= 3'd0;
      rcnt_reg <= 8'(srwg_pkg::HWRST_CYC);
      sec_reg  <= 1'b0;
      fac_reg  <= 1'b0;
      cust_reg <= 1'b0;
      rv_reg   <= 1'b0;
      re_reg   <= 1'b0;
      rd_reg   <= 16'h0000;
    end
    else
    begin
      st_reg   <= st_next;
      cur_reg  <= cur_next;
      idx_reg  <= idx_next;
      rcnt_reg <= rcnt_next;
      sec_reg  <= sec_next;
      fac_reg  <= fac_next;
      cust_reg <= cust_next;
      rv_reg   <= rv_next;
      re_reg   <= re_next;
      rd_reg   <= rd_next;
    end
  end

  // pin-level cycle engine
  srwg_bus_cycle u_cycle
  (
    .clk   (clk),
    .rst   (rst),
    .start (eng_start),
    .step  (step),
    .dq_in (dq_in),
    .busy  (eng_busy),
    .done  (eng_done),
    .rdata (eng_rdata),
    .pins  (pins)
  );

  assign flash_reset_n      = (st_reg != ST_HWRST);
  assign rsp_valid          = rv_reg;
  assign rsp_err            = re_reg;
  assign rsp_data           = rd_reg;
  assign secured_mode       = sec_reg;
  assign factory_lock_flag  = fac_reg;
  assign customer_lock_flag = cust_reg;

  // array reads are refused while secured mode is on
  property p_array_blocked;
    @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_ready && cmd.op == srwg_pkg::OP_READ_ARRAY && sec_reg)
        |=> (rsp_valid && rsp_err && cmd_ready);
  endproperty
  a_array_blocked: assert property (p_array_blocked) else $error("array read passed in secured mode");

  // locking is only attempted from secured mode
  property p_lock_needs_enter;
    @(posedge clk) disable iff (rst)
      (cmd_valid && cmd_ready && cmd.op == srwg_pkg::OP_LOCK_CUST && !sec_reg) |=> (rsp_valid && rsp_err);
  endproperty
  a_lock_needs_enter: assert property (p_lock_needs_enter) else $error("lock issued outside secured mode");

  // secured reads are only issued after the enter sequence
  property p_sec_read_after_enter;
    @(posedge clk) disable iff (rst)
      (eng_start && cur_reg.op == srwg_pkg::OP_READ_SEC) |-> sec_reg;
  endproperty
  a_sec_read_after_enter: assert property (p_sec_read_after_enter) else $error("secured read without enter");

  // no write strobe while the device reset pin is held low
  property p_no_write_in_reset;
    @(posedge clk) disable iff (rst)
      !flash_reset_n |-> (pins.we_n && pins.cs_n);
  endproperty
  a_no_write_in_reset: assert property (p_no_write_in_reset) else $error("write during device reset");

  // each unlock cycle is a whole bus cycle: the engine is free when a step is issued
  property p_engine_free;
    @(posedge clk) disable iff (rst)
      eng_start |-> !eng_busy;
  endproperty
  a_engine_free: assert property (p_engine_free) else $error("bus cycle issued while engine busy");

  c_enter: cover property (@(posedge clk) disable iff (rst) $rose(sec_reg));
  c_lock:  cover property (@(posedge clk) disable iff (rst) $rose(cust_reg));
  c_exit:  cover property (@(posedge clk) disable iff (rst) $fell(sec_reg) && flash_reset_n);
  c_refuse: cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp_err);

endmodule

// >>> test/srwg_flash_model.sv
`timescale 1ns/1ns
module srwg_flash_model
(
  input  wire logic                   clk,
  input  srwg_pkg::srwg_pins_t        pins,
  input  wire logic                   flash_reset_n,
  input  wire logic                   supply_ok,
  output logic [srwg_pkg::DATA_W-1:0] dq_in
);
  logic [15:0] smem [128];
  logic [15:0] rd_word;
  logic [15:0] hold_q = 16'h0000;
  logic [2:0]  st     = 3'h0;
  logic        sec    = 1'h0;  // starts in array read mode
  logic        lock   = 1'h0;  // customer half ships open
  logic        qry    = 1'h0;
  logic [22:0] a;
  logic [15:0] d;

  // factory half preset, customer half erased
  initial
    for (int i = 0; i < 128; i++)
      smem[i] = (i < 64) ? 16'hc000 + 16'(i) : 16'hffff;

  // command decoder on the rising write strobe; no bypass or acceleration path exists
  always @(posedge pins.we_n or negedge flash_reset_n or negedge supply_ok)
  begin
    a = pins.addr;
    d = pins.dq_out;
    if (!flash_reset_n || !supply_ok)
    begin
      st = 3'h0;
      sec = 1'h0;
      qry = 1'h0;
    end
    else if (!pins.cs_n && pins.oe_n)
      case (st)
        3'h0:
          if (a == 23'h00_0555 && d == 16'h00aa) st = 3'h1;
          else if (a == 23'h00_0055 && d == 16'h0098) qry = 1'h1;
          else if (d == 16'h00f0) qry = 1'h0;
          else if (sec && a == 23'h00_0002 && d == 16'h0060) st = 3'h5;
        3'h1: st = (a == 23'h00_02aa && d == 16'h0055) ? 3'h2 : 3'h0;
        3'h2:
        begin
          st = 3'h0;
          if (a == 23'h00_0555 && d == 16'h0088) sec = 1'h1;
          if (a == 23'h00_0555 && d == 16'h0090) st = 3'h4;
          if (a == 23'h00_0555 && d == 16'h00a0) st = 3'h3;
        end
        3'h3:
        begin
          st = 3'h0;
          if (sec && a >= 23'h00_0040 && a <= 23'h00_007f && !lock)
            smem[a[6:0]] = smem[a[6:0]] & d;
        end
        3'h4:
        begin
          st = 3'h0;
          if (d == 16'h0000) sec = 1'h0;
        end
        default:
        begin
          st = 3'h0;
          if (a == 23'h00_0002 && d == 16'h0060) lock = 1'h1;  // one-way lock
        end
      endcase
  end

  // read data: query word, array, secured words with lock flags at word 0
  always_comb
  begin
    if (qry)
      rd_word = 16'h0051;
    else if (!sec)
      rd_word = pins.addr[15:0] ^ 16'h3c3c;
    else if (pins.addr > 23'h00_007f)
      rd_word = 16'h0000;
    else
      rd_word = smem[pins.addr[6:0]];
    if (sec && pins.addr == 23'h00_0000)
    begin
      rd_word[7] = 1'h1;
      rd_word[6] = lock;
    end
  end

  // released lines show the inverse of the last driven word
  always @(posedge clk)
    if (!pins.cs_n && !pins.oe_n)
      hold_q <= rd_word;
  assign dq_in = (!pins.cs_n && !pins.oe_n && !pins.dq_oe) ? rd_word : ~hold_q;
endmodule

// >>> test/srwg_host_tb.sv
`timescale 1ns/1ns
module srwg_host_tb;
  logic                 clk;
  logic                 rst;
  logic                 cmd_valid;
  srwg_pkg::srwg_cmd_t  cmd;
  logic                 cmd_ready;
  logic                 rsp_valid;
  logic                 rsp_err;
  logic [15:0]          rsp_data;
  logic                 secured_mode;
  logic                 factory_lock_flag;
  logic                 customer_lock_flag;
  logic                 supply_ok;
  logic [15:0]          dq_in;
  srwg_pkg::srwg_pins_t pins;
  logic                 flash_reset_n;
  int                   err_count;
  int                   num_checks;
  logic                 sec;
  logic                 lock;
  logic                 hlock;
  int                   smem [128];
  logic [31:0]          r;

  srwg_host dut
  (
    .clk, .rst, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_err, .rsp_data, .secured_mode,
    .factory_lock_flag, .customer_lock_flag, .supply_ok, .dq_in, .pins, .flash_reset_n
  );
  srwg_flash_model flash
  (
    .clk, .pins, .flash_reset_n, .supply_ok, .dq_in
  );

  // free-running clock, 50 ns period
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  // bounded wait on falling edges for ready or response
  task automatic wait_hi(logic rsp);
    int n;
    n = 0;
    while ((rsp ? rsp_valid : cmd_ready) !== 1'h1)
    begin
      @(negedge clk);
      n++;
      if (n > 600)
      begin
        err_count++;
        test_done();
      end
    end
  endtask

  // one command through the host, checked against the reference model
  task automatic run(srwg_pkg::srwg_op_t op, logic [22:0] a, logic [15:0] d);
    logic        e_err;
    logic [15:0] e_dat;
    e_dat = (op == srwg_pkg::OP_READ_SEC) ? 16'(smem[a[6:0]]) : a[15:0] ^ 16'h3c3c;
    case (op)
      srwg_pkg::OP_READ_ARRAY: e_err = sec;
      srwg_pkg::OP_READ_SEC:   e_err = !sec || a > 23'h00_007f;
      srwg_pkg::OP_READ_FLAGS: e_err = !sec;
      srwg_pkg::OP_PROG_SEC:   e_err = !sec || a < 23'h00_0040 || a > 23'h00_007f || hlock;
      srwg_pkg::OP_LOCK_CUST:  e_err = !sec || hlock;
      default:                 e_err = 1'h0;
    endcase
    if (!supply_ok && op == srwg_pkg::OP_ENTER_SEC)
      e_err = 1'h1;
    wait_hi(1'h0);
    cmd_valid = 1'h1;
    cmd = '{op: op, addr: a, data: d};
    @(negedge clk);
    cmd_valid = 1'h0;
    wait_hi(1'h1);
    chk_bit(rsp_err, e_err);
    if (!e_err && (op == srwg_pkg::OP_READ_ARRAY || op == srwg_pkg::OP_READ_SEC))
      chk_word(rsp_data, e_dat);
    if (!e_err)
      case (op)
        srwg_pkg::OP_ENTER_SEC:  sec = 1'h1;
        srwg_pkg::OP_EXIT_SEC:   sec = 1'h0;
        srwg_pkg::OP_HW_RESET:   sec = 1'h0;
        srwg_pkg::OP_PROG_SEC:   smem[a[6:0]] &= d;
        srwg_pkg::OP_LOCK_CUST:  {lock, hlock} = 2'h3;
        srwg_pkg::OP_READ_FLAGS: hlock |= lock;
        default:                 ;
      endcase
    @(negedge clk);
    chk_bit(secured_mode, sec);
    chk_bit(customer_lock_flag, hlock);
    if (op == srwg_pkg::OP_READ_FLAGS && !e_err)
      chk_bit(factory_lock_flag, 1'h1);
  endtask

  // main sequence
  initial
  begin
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd = '0;
    supply_ok = 1'h1;
    err_count = 0;
    num_checks = 0;
    {sec, lock, hlock} = 3'h0;
    for (int i = 0; i < 128; i++)
      smem[i] = (i < 64) ? 32'h0000_c000 + i : 32'h0000_ffff;
    r = $urandom(32'h0000_652d);
    repeat (12) @(negedge clk);
    rst = 1'h0;
    run(srwg_pkg::OP_READ_ARRAY, 23'($urandom), 16'h0000);
    run(srwg_pkg::OP_READ_SEC, 23'h00_0010, 16'h0000);
    run(srwg_pkg::OP_LOCK_CUST, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_ENTER_SEC, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_ARRAY, 23'h00_1234, 16'h0000);
    run(srwg_pkg::OP_READ_FLAGS, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_SEC, 23'h00_003f, 16'h0000);
    run(srwg_pkg::OP_READ_SEC, 23'h00_0080, 16'h0000);
    run(srwg_pkg::OP_PROG_SEC, 23'h00_003f, 16'h0000);
    run(srwg_pkg::OP_PROG_SEC, 23'h00_0080, 16'h0000);
    r = $urandom;
    run(srwg_pkg::OP_PROG_SEC, 23'h00_0040, r[15:0]);
    run(srwg_pkg::OP_READ_SEC, 23'h00_0040, 16'h0000);
    run(srwg_pkg::OP_LOCK_CUST, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_LOCK_CUST, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_PROG_SEC, 23'h00_007f, 16'h0000);
    run(srwg_pkg::OP_READ_FLAGS, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_EXIT_SEC, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_ARRAY, 23'($urandom), 16'h0000);
    run(srwg_pkg::OP_QUERY, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_RESET_CMD, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_ARRAY, 23'($urandom), 16'h0000);
    supply_ok = 1'h0;
    repeat (4) @(negedge clk);
    run(srwg_pkg::OP_ENTER_SEC, 23'h00_0000, 16'h0000);
    supply_ok = 1'h1;
    repeat (4) @(negedge clk);
    run(srwg_pkg::OP_ENTER_SEC, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_HW_RESET, 23'h00_0000, 16'h0000);
    repeat (4) run(srwg_pkg::OP_READ_ARRAY, 23'($urandom), 16'h0000);
    rst = 1'h1;
    @(negedge clk);
    chk_bit(customer_lock_flag, 1'h0);
    chk_bit(flash_reset_n, 1'h0);
    rst = 1'h0;
    {sec, hlock} = 2'h0;
    run(srwg_pkg::OP_ENTER_SEC, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_FLAGS, 23'h00_0000, 16'h0000);
    run(srwg_pkg::OP_READ_SEC, 23'h00_0040, 16'h0000);
    test_done();
  end
endmodule
